/* File: src/lfa_consts.vh */
`ifndef LFA_CONSTS_VH
`define LFA_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LFA_ADDR_W 10
`define LFA_LOOP0_CTRL_OFS 10'h2c2
`define LFA_LOOP0_PHASE_OFS 10'h2c3
`define LFA_LOOP0_FREQ_OFS 10'h2c4
`define LFA_LOOP1_CTRL_OFS 10'h2c5
`define LFA_LOOP1_PHASE_OFS 10'h2c6
`define LFA_LOOP1_FREQ_OFS 10'h2c7
`define LFA_LOOP2_CTRL_OFS 10'h2c8
`define LFA_LOOP2_PHASE_OFS 10'h2c9
`define LFA_LOOP2_FREQ_OFS 10'h2ca
`define LFA_FLAGS_OFS 10'h2ce
`define LFA_CHG_LIM_OFS 10'h2cf
`define LFA_LOOP_STRIDE 10'h003

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LFA_CTRL_RST 8'h01
`define LFA_PHASE_RST 8'hff
`define LFA_FREQ_RST 8'h04
`define LFA_FLAGS_RST 8'h00
`define LFA_CHG_LIM_RST 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LFA_CTRL_MASTER_BIT 0
`define LFA_CTRL_FORCE_BIT 1
`define LFA_FLAGS_USED_MSB 5
`define LFA_CHG_LIM_USED_MSB 5

// ----------------------------------------------------------------------
// timing and units
// ----------------------------------------------------------------------
`define LFA_CLK_PERIOD_PS 4000
`define LFA_PHASE_STEP_NS 250
`define LFA_PHASE_STEP_CYC ((`LFA_PHASE_STEP_NS * 1000) / `LFA_CLK_PERIOD_PS)
`define LFA_FREQ_STEP_PPM 1
`define LFA_FREQ_MAX_PPM 255

`endif

/* File: src/lfa_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "lfa_consts.vh"

module lfa_regs #(
	parameter LOOPS = 3,
	parameter DW = 8
) (
	input wire clk_sys_i,
	input wire nrst_i,
	input wire [`LFA_ADDR_W-1:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [DW-1:0] reg_wdata_i,
	input wire reg_rd_i,
	output reg [DW-1:0] reg_rdata_o,
	input wire [LOOPS*DW-1:0] phase_err_i,
	input wire [LOOPS*DW-1:0] freq_err_i,
	output reg [LOOPS-1:0] quick_acquire_o,
	output wire [LOOPS-1:0] master_en_o,
	output wire [2*LOOPS-1:0] flags_o,
	output wire [DW-1:0] chg_lim_ctrl_o
);

	// ------------------------------------------------------------------
	// shared state
	// ------------------------------------------------------------------
	reg [2*LOOPS-1:0] flags_q;
	reg [2*LOOPS-1:0] flags_d;
	reg [`LFA_CHG_LIM_USED_MSB:0] chg_lim_q;
	wire [2*LOOPS-1:0] flag_set;
	wire [LOOPS*DW-1:0] loop_rd;
	wire [LOOPS-1:0] loop_hit;
	wire flags_hit;
	wire chg_hit;
	reg [DW-1:0] rd_mux;
	integer k;
	wire [LOOPS-1:0] acq_next;
	wire flags_we;
	wire [2*LOOPS-1:0] flags_keep;
	wire [DW-1:0] flags_rd;

	// ------------------------------------------------------------------
	// reset values at register width
	// ------------------------------------------------------------------
	localparam [DW-1:0] CTRL_RST = `LFA_CTRL_RST;
	localparam [DW-1:0] PHASE_RST = `LFA_PHASE_RST;
	localparam [DW-1:0] FREQ_RST = `LFA_FREQ_RST;
	localparam [DW-1:0] FLAGS_RST = `LFA_FLAGS_RST;
	localparam [DW-1:0] CHG_LIM_RST = `LFA_CHG_LIM_RST;

	assign flags_hit = (reg_addr_i == `LFA_FLAGS_OFS);
	assign chg_hit = (reg_addr_i == `LFA_CHG_LIM_OFS);
	assign flags_we = reg_wr_i && flags_hit;
	assign flags_keep = reg_wdata_i[2*LOOPS-1:0];
	assign flags_rd = {{(DW-2*LOOPS){1'b0}}, flags_q};
	assign flags_o = flags_q;
	assign chg_lim_ctrl_o = {{(DW-`LFA_CHG_LIM_USED_MSB-1){1'b0}}, chg_lim_q};

	// ------------------------------------------------------------------
	// per loop registers
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LOOPS; g = g + 1) begin : g_loop
			wire [`LFA_ADDR_W-1:0] base;
			wire ctrl_hit;
			wire ph_hit;
			wire fr_hit;
			wire ph_exc;
			wire fr_exc;
			wire [DW-1:0] ph_err;
			wire [DW-1:0] fr_err;
			reg [1:0] ctrl_q;
			reg [DW-1:0] ph_lim_q;
			reg [DW-1:0] fr_lim_q;

			localparam integer BASE_OFS = `LFA_LOOP0_CTRL_OFS +
				`LFA_LOOP_STRIDE * g;

			assign base = BASE_OFS[`LFA_ADDR_W-1:0];
			assign ctrl_hit = (reg_addr_i == base);
			assign ph_hit = (reg_addr_i == base + 10'h001);
			assign fr_hit = (reg_addr_i == base + 10'h002);
			assign loop_hit[g] = ctrl_hit | ph_hit | fr_hit;
			assign ph_err = phase_err_i[g*DW +: DW];
			assign fr_err = freq_err_i[g*DW +: DW];

			always @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					ctrl_q <= CTRL_RST[1:0];
				end else if (reg_wr_i && ctrl_hit) begin
					ctrl_q <= reg_wdata_i[1:0];
				end
			end

			always @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					ph_lim_q <= PHASE_RST;
				end else if (reg_wr_i && ph_hit) begin
					ph_lim_q <= reg_wdata_i;
				end
			end

			always @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					fr_lim_q <= FREQ_RST;
				end else if (reg_wr_i && fr_hit) begin
					fr_lim_q <= reg_wdata_i;
				end
			end

			assign ph_exc = (ph_lim_q != {DW{1'b0}}) && (ph_err > ph_lim_q);
			assign fr_exc = (fr_lim_q != {DW{1'b0}}) && (fr_err > fr_lim_q);

			assign flag_set[2*g] = ph_exc;
			assign flag_set[2*g+1] = fr_exc;

			assign master_en_o[g] = ctrl_q[`LFA_CTRL_MASTER_BIT];

			assign acq_next[g] = ctrl_q[`LFA_CTRL_MASTER_BIT] &
				(ctrl_q[`LFA_CTRL_FORCE_BIT] | ph_exc | fr_exc);

			assign loop_rd[g*DW +: DW] =
				ctrl_hit ? {{(DW-2){1'b0}}, ctrl_q} :
				ph_hit ? ph_lim_q :
				fr_hit ? fr_lim_q : {DW{1'b0}};
		end
	endgenerate

	// ------------------------------------------------------------------
	// quick acquire request
	// ------------------------------------------------------------------
	// one flop per loop, all in one register with a single driver
	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			quick_acquire_o <= {LOOPS{1'b0}};
		end else begin
			quick_acquire_o <= acq_next;
		end
	end

	// ------------------------------------------------------------------
	// sticky flags
	// ------------------------------------------------------------------
	always @* begin
		flags_d = flags_q;
		if (flags_we) begin
			flags_d = flags_q & flags_keep;
		end
		flags_d = flags_d | flag_set;
	end

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_q <= FLAGS_RST[2*LOOPS-1:0];
		end else begin
			flags_q <= flags_d;
		end
	end

	// ------------------------------------------------------------------
	// change limiter control storage
	// ------------------------------------------------------------------
	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chg_lim_q <= CHG_LIM_RST[`LFA_CHG_LIM_USED_MSB:0];
		end else if (reg_wr_i && chg_hit) begin
			chg_lim_q <= reg_wdata_i[`LFA_CHG_LIM_USED_MSB:0];
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	always @* begin
		rd_mux = {DW{1'b0}};
		for (k = 0; k < LOOPS; k = k + 1) begin
			if (loop_hit[k]) begin
				rd_mux = loop_rd[k*DW +: DW];
			end
		end
		if (flags_hit) begin
			rd_mux = flags_rd;
		end
		if (chg_hit) begin
			rd_mux = chg_lim_ctrl_o;
		end
	end

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= {DW{1'b0}};
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end

endmodule // lfa_regs

`default_nettype wire

/* File: test/lfa_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// flag and bus checks
// ----
module lfa_regs_assertions (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [9:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [23:0] phase_err_i,
	input wire logic [23:0] freq_err_i,
	input wire logic [2:0] quick_acquire_o,
	input wire logic [2:0] master_en_o,
	input wire logic [5:0] flags_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!nrst_i);
sticky_flags_a: assert property (
	!(reg_wr_i && reg_addr_i == 10'h2ce) |=>
	(flags_o & $past(flags_o)) == $past(flags_o)) else $error("flag lost");
flag_cause_a: assert property (
	$rose(flags_o[0]) |-> $past(phase_err_i[7:0]) > 8'h01)
	else $error("flag without error");
acq_master_a: assert property (
	1'b1 |=> (quick_acquire_o & ~$past(master_en_o)) == 3'b000)
	else $error("acquire with master off");
acq_flag_a: assert property (
	$rose(flags_o[2]) && $past(master_en_o[1]) |-> quick_acquire_o[1])
	else $error("flag without acquire");
read_flags_a: assert property (
	reg_rd_i && reg_addr_i == 10'h2ce |=>
	reg_rdata_o == {2'b00, $past(flags_o)}) else $error("flag read");
clear_flags_a: assert property (
	reg_wr_i && reg_addr_i == 10'h2ce && phase_err_i == 24'h0 &&
	freq_err_i == 24'h0
	|=> flags_o == ($past(flags_o) & $past(reg_wdata_i[5:0])))
	else $error("flag clear");
rdata_hold_a: assert property (
	!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
master_hold_a: assert property (
	!reg_wr_i |=> $stable(master_en_o)) else $error("master moved");
cover property ($rose(quick_acquire_o[0]));
cover property ($fell(flags_o[2]));
cover property (reg_wr_i && reg_addr_i == 10'h2ce);
endmodule // lfa_regs_assertions
bind lfa_regs lfa_regs_assertions u_chk (.clk_sys_i, .nrst_i, .reg_addr_i,
	.reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .phase_err_i,
	.freq_err_i, .quick_acquire_o, .master_en_o, .flags_o);
`default_nettype wire

/* File: test/lfa_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// register bench
// ----
module lfa_regs_tb;
logic clk_sys_i = 0, nrst_i = 0, wr = 0, rd = 0;
logic [9:0] a = 0;
logic [7:0] wd = 0, rdat;
logic [23:0] pe = 0, fe = 0;
logic [2:0] qa, me;
logic [5:0] fl;
logic [7:0] cl;
int fail_count = 0, checked = 0, cyc = 0;
always #2 clk_sys_i = ~clk_sys_i;
lfa_regs uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(a),
	.reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdat),
	.phase_err_i(pe), .freq_err_i(fe), .quick_acquire_o(qa),
	.master_en_o(me), .flags_o(fl), .chg_lim_ctrl_o(cl));
task automatic chk(input logic [7:0] g, input logic [7:0] e);
	checked++;
	if (g !== e) begin
		fail_count++;
		$display("unexpected %0t: got %h want %h", $time, g, e);
	end
endtask
task automatic wrt(input logic [9:0] ad, input logic [7:0] d);
	@(posedge clk_sys_i);
	a <= ad;
	wd <= d;
	wr <= 1'b1;
	@(posedge clk_sys_i);
	wr <= 1'b0;
endtask
task automatic rdc(input logic [9:0] ad, input logic [7:0] e);
	@(posedge clk_sys_i);
	a <= ad;
	rd <= 1'b1;
	@(posedge clk_sys_i);
	rd <= 1'b0;
	#1 chk(rdat, e);
endtask
task automatic test_done;
	if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
always @(posedge clk_sys_i) begin
	cyc++;
	if (cyc > 2000) begin
		fail_count++;
		test_done();
	end
end
initial begin
	repeat (8) @(posedge clk_sys_i);
	nrst_i <= 1'b1;
	for (int i = 0; i < 3; i++) begin
		rdc(10'h2c2 + 10'(3 * i), 8'h01);
		rdc(10'h2c3 + 10'(3 * i), 8'hff);
		rdc(10'h2c4 + 10'(3 * i), 8'h04);
	end
	rdc(10'h2ce, 8'h00);
	wrt(10'h2c6, 8'h04);
	wrt(10'h2c4, 8'h00);
	rdc(10'h2c6, 8'h04);
	rdc(10'h2c4, 8'h00);
	@(posedge clk_sys_i);
	pe <= 24'h000500;
	fe <= 24'h050505;
	@(posedge clk_sys_i);
	#1 chk({5'h00, qa}, 8'h06);
	chk({2'b00, fl}, 8'h2c);
	@(posedge clk_sys_i);
	pe <= 24'h0;
	fe <= 24'h0;
	rdc(10'h2ce, 8'h2c);
	wrt(10'h2ce, 8'hfa);
	rdc(10'h2ce, 8'h28);
	wrt(10'h2c2, 8'hfe);
	rdc(10'h2c2, 8'h02);
	chk({5'h00, me}, 8'h06);
	chk({5'h00, qa}, 8'h00);
	wrt(10'h2c2, 8'h03);
	rdc(10'h2c2, 8'h03);
	chk({5'h00, qa}, 8'h01);
	wrt(10'h2c3, 8'h10);
	@(posedge clk_sys_i);
	pe <= 24'h000020;
	wrt(10'h2ce, 8'h00);
	rdc(10'h2ce, 8'h01);
	wrt(10'h2c3, 8'h00);
	wrt(10'h2c2, 8'h01);
	wrt(10'h2ce, 8'h00);
	rdc(10'h2ce, 8'h00);
	chk({5'h00, qa}, 8'h00);
	chk({5'h00, me}, 8'h07);
	wrt(10'h2cf, 8'hff);
	rdc(10'h2cf, 8'h3f);
	chk(cl, 8'h3f);
	@(posedge clk_sys_i);
	pe <= 24'h0;
	fe <= 24'h050000;
	@(posedge clk_sys_i);
	#1 chk({2'b00, fl}, 8'h20);
	@(posedge clk_sys_i);
	nrst_i <= 1'b0;
	fe <= 24'h0;
	@(posedge clk_sys_i);
	nrst_i <= 1'b1;
	#1 chk({2'b00, fl}, 8'h00);
	chk(cl, 8'h00);
	chk({5'h00, qa}, 8'h00);
	chk({5'h00, me}, 8'h07);
	rdc(10'h2c3, 8'hff);
	rdc(10'h2c6, 8'hff);
	test_done();
end
endmodule // lfa_regs_tb
`default_nettype wire
